// [hw/status_leds_and_factory_reset.sv]
// Status indicator lights, factory-reset detection and AXI4-Lite register slave
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "status_led_defines.svh"
module status_leds_and_factory_reset (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  input  wire logic        factoryReset_n,
  input  wire logic        canErrPassive,
  input  wire logic        canBusOff,
  input  wire logic        canErrFrame,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             power_indicator,
  output logic             canIndicator,
  output logic             errIndicator,
  output logic             network_link_indicator,
  output logic             factoryDefaultReboot,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Timing parameters (long counts shortenable for simulation)
  // ----------------------------------------------------------------
  parameter int unsigned HOLD_STEADY_CYC  = `HOLD_STEADY_CYC;
  parameter int unsigned HOLD_ABANDON_CYC = `HOLD_ABANDON_CYC;
  parameter int unsigned DEBOUNCE_CYC     = `DEBOUNCE_CYC;
  parameter int unsigned FAST_HALF_CYC    = `FAST_HALF_CYC;
  parameter int unsigned SLOW_HALF_CYC    = `SLOW_HALF_CYC;
  parameter int unsigned FLASH_CYC        = `FLASH_CYC;

  function automatic logic reached(input logic [31:0] cnt, input int unsigned lim);
    reached = (cnt >= lim - 1);
  endfunction : reached

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] resetSync;
  logic [1:0] passiveSync;
  logic [1:0] busOffSync;
  logic [1:0] frameSync;
  logic       frameSeen;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      resetSync   <= 2'h3;
      passiveSync <= 2'h0;
      busOffSync  <= 2'h0;
      frameSync   <= 2'h0;
      frameSeen   <= 1'b0;
    end else if (clkEn) begin
      resetSync   <= {resetSync[0], factoryReset_n};
      passiveSync <= {passiveSync[0], canErrPassive};
      busOffSync  <= {busOffSync[0], canBusOff};
      frameSync   <= {frameSync[0], canErrFrame};
      frameSeen   <= frameSync[1];
    end
  end

  wire errFrameEvt = frameSync[1] & ~frameSeen;

  // ----------------------------------------------------------------
  // Debounce: pressed means pulled low
  // ----------------------------------------------------------------
  logic        pressed;
  logic [31:0] bounceCnt;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pressed   <= 1'b0;
      bounceCnt <= '0;
    end else if (clkEn) begin
      if (~resetSync[1] == pressed) begin
        bounceCnt <= '0;
      end else if (reached(bounceCnt, DEBOUNCE_CYC)) begin
        pressed   <= ~resetSync[1];
        bounceCnt <= '0;
      end else begin
        bounceCnt <= bounceCnt + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Factory-reset window sequencer
  // ----------------------------------------------------------------
  status_led_pkg::reset_state_t rstState;
  logic [31:0]                  holdCnt;
  logic                         bootSampled;

  // Only a press present when the filter settles after boot counts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rstState    <= status_led_pkg::RST_IDLE;
      holdCnt     <= '0;
      bootSampled <= 1'b0;
    end else if (clkEn) begin
      case (rstState)
        status_led_pkg::RST_IDLE: begin
          if (!bootSampled && reached(holdCnt, DEBOUNCE_CYC + 3)) begin
            bootSampled <= 1'b1;
            holdCnt     <= '0;
            rstState    <= pressed ? status_led_pkg::RST_STEADY : status_led_pkg::RST_DONE;
          end else begin
            holdCnt <= holdCnt + 32'h1;
          end
        end
        status_led_pkg::RST_STEADY: begin
          holdCnt <= holdCnt + 32'h1;
          if (!pressed) begin
            rstState <= status_led_pkg::RST_DONE;
          end else if (reached(holdCnt, HOLD_STEADY_CYC)) begin
            rstState <= status_led_pkg::RST_FLASH;
          end
        end
        status_led_pkg::RST_FLASH: begin
          holdCnt <= holdCnt + 32'h1;
          if (!pressed) begin
            rstState <= status_led_pkg::RST_REBOOT;
          end else if (reached(holdCnt, HOLD_ABANDON_CYC)) begin
            rstState <= status_led_pkg::RST_DONE;
          end
        end
        status_led_pkg::RST_REBOOT: rstState <= status_led_pkg::RST_REBOOT;
        status_led_pkg::RST_DONE:   rstState <= status_led_pkg::RST_DONE;
        default:                    rstState <= status_led_pkg::RST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      factoryDefaultReboot <= 1'b0;
    end else if (clkEn) begin
      factoryDefaultReboot <= (rstState == status_led_pkg::RST_REBOOT);
    end
  end

  // ----------------------------------------------------------------
  // Blink generators
  // ----------------------------------------------------------------
  logic [31:0] fastCnt;
  logic [31:0] slowCnt;
  logic        fastPhase;
  logic        slowPhase;
  logic [31:0] flashCnt;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fastCnt   <= '0;
      slowCnt   <= '0;
      fastPhase <= 1'b0;
      slowPhase <= 1'b0;
    end else if (clkEn) begin
      fastCnt <= reached(fastCnt, FAST_HALF_CYC) ? '0 : fastCnt + 32'h1;
      slowCnt <= reached(slowCnt, SLOW_HALF_CYC) ? '0 : slowCnt + 32'h1;
      if (reached(fastCnt, FAST_HALF_CYC)) begin
        fastPhase <= ~fastPhase;
      end
      if (reached(slowCnt, SLOW_HALF_CYC)) begin
        slowPhase <= ~slowPhase;
      end
    end
  end

  // A frame during a running flash restarts it rather than queuing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flashCnt <= '0;
    end else if (clkEn) begin
      if (errFrameEvt) begin
        flashCnt <= 32'(FLASH_CYC);
      end else if (flashCnt != '0) begin
        flashCnt <= flashCnt - 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]                  ctrl;
  logic [`IRQ_WIDTH-1:0]       irqStat;
  logic [`IRQ_WIDTH-1:0]       irqMask;
  logic [`IRQ_WIDTH-1:0]       irqEvt;
  logic                        awHeld;
  logic                        wHeld;
  logic [7:0]                  awAddr;
  logic [31:0]                 wData;
  logic [3:0]                  wStrb;
  status_led_pkg::can_state_t  canState;

  assign canState = busOffSync[1] ? status_led_pkg::CAN_BUSOFF
                  : passiveSync[1] ? status_led_pkg::CAN_PASSIVE : status_led_pkg::CAN_ACTIVE;
  assign irqEvt = {rstState == status_led_pkg::RST_FLASH && reached(holdCnt, HOLD_ABANDON_CYC) && pressed,
                   rstState == status_led_pkg::RST_FLASH && !pressed,
                   errFrameEvt};

  wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
  // Frozen state cannot take a beat, so readies drop with the enable
  assign s_axi_awready = clkEn & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = clkEn & ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = clkEn & ~s_axi_rvalid;
  assign irq           = |(irqStat & irqMask);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == `REG_CTRL || awAddr == `REG_STATUS || awAddr == `REG_IRQ_STAT
                         || awAddr == `REG_IRQ_MASK) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl    <= 4'h1;
      irqMask <= '0;
    end else if (clkEn && doWrite && wStrb[0]) begin
      if (awAddr == `REG_CTRL) begin
        ctrl <= wData[3:0];
      end
      if (awAddr == `REG_IRQ_MASK) begin
        irqMask <= wData[`IRQ_WIDTH-1:0];
      end
    end
  end

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqStat <= '0;
    end else if (clkEn) begin
      if (doWrite && wStrb[0] && awAddr == `REG_IRQ_STAT) begin
        irqStat <= (irqStat & ~wData[`IRQ_WIDTH-1:0]) | irqEvt;
      end else begin
        irqStat <= irqStat | irqEvt;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          `REG_CTRL:     s_axi_rdata <= {28'h0, ctrl};
          `REG_STATUS:   s_axi_rdata <= {24'h0, pressed, factoryDefaultReboot, canState, 1'b0, rstState};
          `REG_IRQ_STAT: s_axi_rdata <= {29'h0, irqStat};
          `REG_IRQ_MASK: s_axi_rdata <= {29'h0, irqMask};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicator drive
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_indicator        <= 1'b0;
      network_link_indicator <= 1'b0;
      canIndicator           <= 1'b0;
      errIndicator           <= 1'b0;
    end else if (clkEn) begin
      power_indicator <= ctrl[`CTRL_POWER_OK];
      if (ctrl[`CTRL_REMOTE_CONN]) begin
        network_link_indicator <= 1'b1;
      end else if (ctrl[`CTRL_LEASE_WAIT]) begin
        network_link_indicator <= fastPhase;
      end else if (ctrl[`CTRL_REMOTE_READY]) begin
        network_link_indicator <= slowPhase;
      end else begin
        network_link_indicator <= 1'b0;
      end
      // Reset sequence owns both lights; otherwise CAN status drives both, and the error flash drives errIndicator alone
      if (rstState == status_led_pkg::RST_STEADY) begin
        canIndicator <= 1'b1;
        errIndicator <= 1'b1;
      end else if (rstState == status_led_pkg::RST_FLASH || rstState == status_led_pkg::RST_REBOOT) begin
        canIndicator <= fastPhase;
        errIndicator <= fastPhase;
      end else if (canState == status_led_pkg::CAN_BUSOFF) begin
        canIndicator <= slowPhase;
        errIndicator <= slowPhase;
      end else if (canState == status_led_pkg::CAN_PASSIVE) begin
        canIndicator <= fastPhase;
        errIndicator <= fastPhase;
      end else begin
        canIndicator <= 1'b0;
        errIndicator <= (flashCnt != '0);
      end
    end
  end

endmodule : status_leds_and_factory_reset

// [pkg/status_led_defines.svh]
// Timing constants and register map for the status indicator block
`ifndef STATUS_LED_DEFINES_SVH
`define STATUS_LED_DEFINES_SVH

`define CLK_HZ            25000000
`define HOLD_STEADY_S     5
`define HOLD_ABANDON_S    10
`define HOLD_STEADY_CYC   (`HOLD_STEADY_S * `CLK_HZ)
`define HOLD_ABANDON_CYC  (`HOLD_ABANDON_S * `CLK_HZ)
`define DEBOUNCE_MS       10
`define DEBOUNCE_CYC      ((`DEBOUNCE_MS * `CLK_HZ) / 1000)
`define FAST_HALF_MS      100
`define FAST_HALF_CYC     ((`FAST_HALF_MS * `CLK_HZ) / 1000)
`define SLOW_HALF_MS      500
`define SLOW_HALF_CYC     ((`SLOW_HALF_MS * `CLK_HZ) / 1000)
`define FLASH_MS          50
`define FLASH_CYC         ((`FLASH_MS * `CLK_HZ) / 1000)

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STAT      8'h08
`define REG_IRQ_MASK      8'h0C

`define CTRL_POWER_OK     0
`define CTRL_LEASE_WAIT   1
`define CTRL_REMOTE_READY 2
`define CTRL_REMOTE_CONN  3

`define IRQ_ERR_FRAME     0
`define IRQ_REBOOT        1
`define IRQ_ABANDON       2
`define IRQ_WIDTH         3

`endif

// [pkg/status_led_pkg.sv]
// Types shared by the status indicator block
package status_led_pkg;
  typedef enum logic [2:0] {
    RST_IDLE,
    RST_STEADY,
    RST_FLASH,
    RST_REBOOT,
    RST_DONE
  } reset_state_t;

  typedef enum logic [1:0] {
    CAN_ACTIVE,
    CAN_PASSIVE,
    CAN_BUSOFF
  } can_state_t;
endpackage : status_led_pkg

// [tb/status_leds_props.sv]
// Port-level assertions for the status indicator block
`timescale 1ns/100ps
module status_leds_props (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        factoryReset_n,
  input wire logic        canErrPassive,
  input wire logic        canBusOff,
  input wire logic        canErrFrame,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        canIndicator,
  input wire logic        errIndicator,
  input wire logic        factoryDefaultReboot,
  input wire logic        irq
);
  logic [5:0] lowCnt;
  logic       quiet;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Channel light dark longer than the slowest blink half
  always_ff @(posedge core_clk) begin
    if (srst || canIndicator) lowCnt <= 6'h00;
    else if (lowCnt != 6'h3F) lowCnt <= lowCnt + 6'h01;
  end
  assign quiet = (lowCnt > 6'h28) && !canErrPassive && !canBusOff;
  AST_RESET_OUT: assert property ($fell(srst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !factoryDefaultReboot)
    else $error("Outputs not cleared by reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("Write address taken during response");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken during response");
  AST_REBOOT_STICKY: assert property (factoryDefaultReboot |=> factoryDefaultReboot)
    else $error("Reboot request dropped");
  AST_REBOOT_CAUSE: assert property ($rose(factoryDefaultReboot) |-> $past(factoryReset_n, 4))
    else $error("Reboot without button release");
  AST_FRAME_FLASH: assert property ($rose(canErrFrame) && quiet |-> ##[1:8] errIndicator)
    else $error("Error frame gave no flash");
  AST_FLASH_LEN: assert property ($rose(errIndicator) && quiet |-> errIndicator[*5] ##[0:2] !errIndicator)
    else $error("Error flash length wrong");
  cover property ($rose(factoryDefaultReboot));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(errIndicator) && quiet);
endmodule : status_leds_props

bind status_leds_and_factory_reset status_leds_props u_props (.core_clk, .srst, .factoryReset_n, .canErrPassive,
  .canBusOff, .canErrFrame, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .canIndicator, .errIndicator, .factoryDefaultReboot, .irq);

// [tb/reset_fixture.sv]
// Pushbutton fixture model with pull-up and contact bounce
`timescale 1ns/100ps
module reset_fixture (
  input  wire logic core_clk,
  input  wire logic pressCmd,
  output logic      factoryReset_n
);
  logic [1:0] bounce;
  logic       last;
  initial begin
    bounce = 2'h0;
    last = 1'b0;
    factoryReset_n = 1'b1;
  end
  // No CAN lines pass through the fixture
  // Contacts chatter after each change, so the line toggles before it settles
  always @(posedge core_clk) begin
    if (pressCmd != last) bounce <= 2'h3;
    else if (bounce != 2'h0) bounce <= bounce - 2'h1;
    last <= pressCmd;
    factoryReset_n <= (bounce != 2'h0) ? ~factoryReset_n : ~pressCmd; // Pressed grounds, released pulls up
  end
endmodule : reset_fixture

// [tb/tb_top.sv]
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
module tb_top;
  localparam int FAST = 8;
  localparam int SLOW = 32;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clkEn = 1'b1;
  logic        pressCmd = 1'b0;
  logic        canErrPassive = 1'b0;
  logic        canBusOff = 1'b0;
  logic        canErrFrame = 1'b0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        factoryReset_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ok;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic        power_indicator, canIndicator, errIndicator, network_link_indicator, factoryDefaultReboot, irq;
  int          fails = 0;
  int          totalChecks = 0;
  int          n;
  int          i;

  always #20 core_clk = ~core_clk;

  status_leds_and_factory_reset #(.HOLD_STEADY_CYC(200), .HOLD_ABANDON_CYC(400), .DEBOUNCE_CYC(4),
    .FAST_HALF_CYC(FAST), .SLOW_HALF_CYC(SLOW), .FLASH_CYC(5)) uut (
    .core_clk, .srst, .clkEn, .factoryReset_n, .canErrPassive, .canBusOff, .canErrFrame,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .power_indicator,
    .canIndicator, .errIndicator, .network_link_indicator, .factoryDefaultReboot, .irq);
  reset_fixture fixture (.core_clk, .pressCmd, .factoryReset_n);

  task summarize;
    $display("Checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task tmo;
    fails++;
    summarize();
  endtask : tmo

  // Readies are looked at on the falling edge, where nothing the bench drives can move
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awT, wT, bT;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bT = 1'b0;
    for (i = 0; i < 40 && !bT; i++) begin
      @(negedge core_clk);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!bT) tmo();
    chk(r, er);
  endtask : axw

  task axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic arT, rT;
    logic [1:0] r;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rT = 1'b0;
    for (i = 0; i < 40 && !rT; i++) begin
      @(negedge core_clk);
      arT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (arT) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!rT) tmo();
    chk(r, er);
  endtask : axr

  function automatic logic ind(input int w);
    ind = (w == 0) ? power_indicator : (w == 1) ? canIndicator : (w == 2) ? errIndicator : network_link_indicator;
  endfunction : ind

  // Length of the first whole phase after the next change; 200 means no change seen
  task half(input int w, output int len);
    logic v;
    int k;
    @(negedge core_clk);
    v = ind(w);
    for (k = 0; k < 200 && ind(w) == v; k++) @(negedge core_clk);
    v = ind(w);
    len = 0;
    for (k = 0; k < 200 && ind(w) == v; k++) begin
      @(negedge core_clk);
      len++;
    end
  endtask : half

  task steady(input int w, input logic v, output logic good);
    good = 1'b1;
    repeat (70) begin
      @(negedge core_clk);
      if (ind(w) !== v) good = 1'b0;
    end
  endtask : steady

  task doReset(input logic press);
    @(posedge core_clk);
    pressCmd <= press;
    repeat (10) @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
  endtask : doReset

  task regsScenario;
    axr(8'h00, 2'h0, rd);
    chk(rd, 32'h1);
    axr(8'h0C, 2'h0, rd);
    chk(rd, 32'h0);
    axr(8'h10, 2'h2, rd);
    chk(rd, 32'h0);
    axw(8'h10, 32'hFF, 2'h2);
    s_axi_wstrb <= 4'h0;
    axw(8'h00, 32'h0, 2'h0);
    axr(8'h00, 2'h0, rd);
    chk(rd, 32'h1);
    s_axi_wstrb <= 4'hF;
    axw(8'h00, 32'h0, 2'h0);
    repeat (3) @(negedge core_clk);
    chk(power_indicator, 1'b0);
    axw(8'h00, 32'h1, 2'h0);
    repeat (3) @(negedge core_clk);
    chk(power_indicator, 1'b1);
  endtask : regsScenario

  task netScenario;
    axw(8'h00, 32'h3, 2'h0);
    half(3, n);
    half(3, n);
    chk(n, FAST);
    @(posedge core_clk);
    clkEn <= 1'b0;
    @(negedge core_clk);
    steady(3, network_link_indicator, ok);
    chk(ok, 1'b1);
    @(posedge core_clk);
    clkEn <= 1'b1;
    axw(8'h00, 32'h5, 2'h0);
    half(3, n);
    half(3, n);
    chk(n, SLOW);
    axw(8'h00, 32'hB, 2'h0);
    steady(3, 1'b1, ok);
    chk(ok, 1'b1);
    axw(8'h00, 32'h1, 2'h0);
  endtask : netScenario

  task canScenario;
    @(posedge core_clk);
    canErrPassive <= 1'b1;
    half(1, n);
    half(1, n);
    chk(n, FAST);
    half(2, n);
    chk(n, FAST);
    @(posedge core_clk);
    canBusOff <= 1'b1;
    repeat (40) @(negedge core_clk);
    half(1, n);
    chk(n, SLOW);
    half(2, n);
    chk(n, SLOW);
    @(posedge core_clk);
    canErrPassive <= 1'b0;
    canBusOff <= 1'b0;
    repeat (4) @(negedge core_clk);
    steady(1, 1'b0, ok);
    chk(ok, 1'b1);
    @(posedge core_clk);
    canErrFrame <= 1'b1;
    half(2, n);
    chk(n, 5);
    @(posedge core_clk);
    canErrFrame <= 1'b0;
    axr(8'h08, 2'h0, rd);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    axw(8'h0C, 32'h1, 2'h0);
    @(negedge core_clk);
    chk(irq, 1'b1);
    axw(8'h08, 32'h1, 2'h0);
    @(negedge core_clk);
    chk(irq, 1'b0);
  endtask : canScenario

  task bootScenario;
    doReset(1'b1);
    for (i = 0; i < 50 && !canIndicator; i++) @(negedge core_clk);
    ok = 1'b1;
    for (n = 0; n < 300 && canIndicator; n++) begin
      if (!errIndicator) ok = 1'b0;
      @(negedge core_clk);
    end
    chk(ok, 1'b1);
    chk(n >= 195 && n <= 215, 1'b1);
    @(posedge core_clk);
    pressCmd <= 1'b0;
    for (i = 0; i < 40 && !factoryDefaultReboot; i++) @(negedge core_clk);
    chk(factoryDefaultReboot, 1'b1);
    axr(8'h08, 2'h0, rd);
    chk(rd, 32'h2);
  endtask : bootScenario

  task abandonScenario;
    doReset(1'b1);
    repeat (480) @(negedge core_clk);
    steady(1, 1'b0, ok);
    chk(ok, 1'b1);
    steady(2, 1'b0, ok);
    chk(ok, 1'b1);
    axr(8'h04, 2'h0, rd);
    chk(rd[2:0], 3'h4);
    axr(8'h08, 2'h0, rd);
    chk(rd, 32'h4);
    @(posedge core_clk);
    pressCmd <= 1'b0;
    repeat (40) @(negedge core_clk);
    chk(factoryDefaultReboot, 1'b0);
  endtask : abandonScenario

  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    regsScenario();
    netScenario();
    canScenario();
    bootScenario();
    abandonScenario();
    summarize();
  end
endmodule : tb_top
